// file: design/aaim_pkg.sv
/*
 * Package for the antenna alarm and interlock monitor.
 * Holds alarm codes, priority order, timing constants and carrier structs.
 * Assumes one 25 MHz clock and an active-high asynchronous reset.
 */
package aaim_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_AXES = 3;            // Azimuth, elevation, polarization
   localparam int ADC_W = 10;              // Battery converter width
   localparam int CODE_W = 5;              // Alarm code width
   localparam int TMO_W = 32;              // Jam timeout counter width

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 25000000;       // Reference clock rate
   localparam int FLASH_MS = 500;          // Half period of alarm flashing
   localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
   localparam logic [ADC_W-1:0] BATT_LOW_RST = 10'h200; // Threshold after reset

   // ----------------------------------------------------------------
   // Alarm codes, highest priority has the lowest number
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] ALM_NONE = 5'h00;
   localparam logic [CODE_W-1:0] ALM_VER_MISMATCH = 5'h01;
   localparam logic [CODE_W-1:0] ALM_DATA_CORRUPT = 5'h02;
   localparam logic [CODE_W-1:0] ALM_LOW_BATT = 5'h03;
   localparam logic [CODE_W-1:0] ALM_TIME_DATE = 5'h04;
   localparam logic [CODE_W-1:0] ALM_JAM_AZ = 5'h05;
   localparam logic [CODE_W-1:0] ALM_JAM_EL = 5'h06;
   localparam logic [CODE_W-1:0] ALM_JAM_POL = 5'h07;
   localparam logic [CODE_W-1:0] ALM_RUN_AZ = 5'h08;
   localparam logic [CODE_W-1:0] ALM_RUN_EL = 5'h09;
   localparam logic [CODE_W-1:0] ALM_RUN_POL = 5'h0a;
   localparam logic [CODE_W-1:0] ALM_LIMITS_OFF = 5'h0b;
   localparam logic [CODE_W-1:0] ALM_OVERTEMP = 5'h0c;
   localparam logic [CODE_W-1:0] ALM_DRIVE_ERR = 5'h0d;
   localparam logic [CODE_W-1:0] ALM_ESTOP = 5'h0e;
   localparam logic [CODE_W-1:0] ALM_CRANKS = 5'h0f;
   localparam logic [CODE_W-1:0] ALM_EL_ILOCK = 5'h10;
   localparam logic [CODE_W-1:0] ALM_MOVE_ILOCK = 5'h11;
   localparam logic [CODE_W-1:0] ALM_PENDANT = 5'h12;
   localparam int NUM_ALM = 18;            // Codes 1 to 18

   // ----------------------------------------------------------------
   // Carrier structs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ver_mismatch;                  // Stored data version wrong
      logic data_corrupt;                  // Stored data corrupt
      logic time_bad;                      // Stored time invalid
      logic date_bad;                      // Stored date invalid
      logic limits_off;                    // Limit inhibit disabled
      logic overtemp;                      // Motor over-temperature
      logic drive_err;                     // External drive error
      logic estop;                         // Emergency stop pressed
      logic cranks_unsafe;                 // Hand cranks out of place
      logic el_ilock_unsafe;               // Elevation interlock open
      logic move_ilock_unsafe;             // Movement interlock open
      logic pendant;                       // Jog pendant connected
   } aaim_src_s;

   typedef struct packed {
      logic overtemp;                      // Over-temp sense wired
      logic drive_err;                     // Drive error feedback wired
      logic cranks;                        // Crank feedback wired
      logic el_ilock;                      // Elevation interlock wired
      logic move_ilock;                    // Movement interlock wired
   } aaim_fit_s;

   // Per-axis state for the jam watch
   typedef enum logic [2:0] {
      AX_IDLE = 3'b001,
      AX_MOVING = 3'b010,
      AX_FAULT = 3'b100
   } aaim_ax_e;

endpackage

// file: design/aaim_axis_watch.sv
/*
 * Per-axis jam and runaway watch.
 * Assumes cmd and moved come from logic on the same clock; moved is a
 * one-cycle pulse per detected position change.
 */
`timescale 1ns/1ps
module aaim_axis_watch
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cmd,
   input wire logic moved,
   input wire logic [aaim_pkg::TMO_W-1:0] timeout,
   input wire logic fault_reset,
   output logic jam,
   output logic runaway
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   aaim_pkg::aaim_ax_e state;              // Watch state
   logic [aaim_pkg::TMO_W-1:0] wait_cnt;   // Cycles since last movement

   // Jam: commanded but no movement within the timeout; latched
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= aaim_pkg::AX_IDLE;
         wait_cnt <= '0;
         jam <= 1'b0;
      end
      else
      begin
         case (state)
            aaim_pkg::AX_IDLE:
            begin
               wait_cnt <= '0;
               if (cmd)
                  state <= aaim_pkg::AX_MOVING;
            end
            aaim_pkg::AX_MOVING:
            begin
               if (!cmd)
                  state <= aaim_pkg::AX_IDLE;
               else if (moved)
                  wait_cnt <= '0;            // Progress seen, restart wait
               else if (wait_cnt >= timeout)
               begin
                  jam <= 1'b1;               // [RULE8]
                  state <= aaim_pkg::AX_FAULT;
               end
               else
                  wait_cnt <= wait_cnt + 1'b1;
            end
            aaim_pkg::AX_FAULT:
            begin
               // Held until an explicit reset pulse
               if (fault_reset)
               begin
                  jam <= 1'b0;               // [RULE22]
                  state <= aaim_pkg::AX_IDLE;
               end
            end
            default:
               state <= aaim_pkg::AX_IDLE;
         endcase
      end
   end

   // Runaway: movement while nothing is commanded; a new event wins
   // over a reset in the same cycle so it is never lost
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         runaway <= 1'b0;
      else if (moved && !cmd)
         runaway <= 1'b1;                    // [RULE10]
      else if (fault_reset)
         runaway <= 1'b0;                    // [RULE22]
   end

endmodule

// file: design/aaim_monitor.sv
/*
 * Antenna alarm and interlock monitor top.
 * Scans alarm sources in fixed priority order, presents the highest
 * active code with a flashing flag, and gates axis motion commands.
 * Assumes pin-level sources arrive asynchronously and are synchronised
 * here; motion commands, move pulses and battery samples are on ref_clk.
 */
`timescale 1ns/1ps
// Contract
// [RULE1] Scan alarms in priority order, show highest
// [RULE2] Cleared alarm gives way to next lower
// [RULE3] Flash message whenever any alarm exists
// [RULE4] Alarm on stored data version mismatch
// [RULE5] Alarm on corrupt stored data
// [RULE6] Low battery alarm from 10-bit sample
// [RULE7] Alarm on invalid time or date
// [RULE8] Jam when commanded axis fails to move
// [RULE9] Jammed axis blocks motion until reset
// [RULE10] Runaway when axis moves uncommanded
// [RULE11] Runaway axis blocks motion until reset
// [RULE12] Warn when limit inhibit is disabled
// [RULE13] Fitted over-temp input raises alarm
// [RULE14] Wired drive-error input raises alarm
// [RULE15] Emergency stop alarm follows the switch
// [RULE16] Emergency stop inhibits all axis motion
// [RULE17] Fitted crank feedback unsafe raises alarm
// [RULE18] Fitted elevation interlock unsafe raises alarm
// [RULE19] Fitted movement interlock unsafe raises alarm
// [RULE20] Pendant alarm; reject remote motion requests
// [RULE21] Priority follows the listed order
// [RULE22] Per-axis timeout count, per-axis reset pulse
module aaim_monitor
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire aaim_pkg::aaim_src_s src_pin,
   input wire aaim_pkg::aaim_fit_s fitted,
   input wire logic [aaim_pkg::ADC_W-1:0] batt_sample,
   input wire logic batt_valid,
   input wire logic [aaim_pkg::ADC_W-1:0] batt_low_thresh,
   input wire logic [aaim_pkg::NUM_AXES-1:0] local_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] remote_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] axis_moved,
   input wire logic [aaim_pkg::TMO_W-1:0] jam_timeout_az,
   input wire logic [aaim_pkg::TMO_W-1:0] jam_timeout_el,
   input wire logic [aaim_pkg::TMO_W-1:0] jam_timeout_pol,
   input wire logic [aaim_pkg::NUM_AXES-1:0] fault_reset,
   output logic [aaim_pkg::CODE_W-1:0] alarm_code,
   output logic alarm_any,
   output logic alarm_flash_on,
   output logic [aaim_pkg::NUM_AXES-1:0] drive_cmd,
   output logic [aaim_pkg::NUM_AXES-1:0] axis_jam,
   output logic [aaim_pkg::NUM_AXES-1:0] axis_runaway,
   output logic remote_rejected
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   aaim_pkg::aaim_src_s src_meta;          // First stage, read only by second
   aaim_pkg::aaim_src_s src_sync;          // Safe copy of the pins

   // Two flops for every asynchronous source pin
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         src_meta <= '0;
         src_sync <= '0;
      end
      else
      begin
         src_meta <= src_pin;
         src_sync <= src_meta;
      end
   end

   // ----------------------------------------------------------------
   // Battery level
   // ----------------------------------------------------------------
   logic batt_low;                         // Latest sample below threshold

   // Re-judged on every fresh sample; holds between samples
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         batt_low <= 1'b0;
      else if (batt_valid)
         batt_low <= (batt_sample < batt_low_thresh); // [RULE6]
   end

   // ----------------------------------------------------------------
   // Axis watches
   // ----------------------------------------------------------------
   logic [aaim_pkg::NUM_AXES-1:0] jam_w;   // Latched jam per axis
   logic [aaim_pkg::NUM_AXES-1:0] run_w;   // Latched runaway per axis
   logic [aaim_pkg::NUM_AXES-1:0] want;    // Gated motion the drive is told
   logic [aaim_pkg::TMO_W-1:0] tmo [aaim_pkg::NUM_AXES]; // Timeout per axis

   assign tmo[0] = jam_timeout_az;
   assign tmo[1] = jam_timeout_el;
   assign tmo[2] = jam_timeout_pol;

   // Jam watch judges what the drive is actually told, not raw requests
   assign want = drive_cmd;

   genvar g;
   generate
      for (g = 0; g < aaim_pkg::NUM_AXES; g++)
      begin : g_axis
         aaim_axis_watch u_watch
         (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .cmd(want[g]),
            .moved(axis_moved[g]),
            .timeout(tmo[g]),         // [RULE22]
            .fault_reset(fault_reset[g]),
            .jam(jam_w[g]),
            .runaway(run_w[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Alarm vector, bit index equals alarm code
   // ----------------------------------------------------------------
   logic [aaim_pkg::NUM_ALM:0] active;     // Bit 0 unused

   always_comb
   begin
      active = '0;
      active[aaim_pkg::ALM_VER_MISMATCH] = src_sync.ver_mismatch;      // [RULE4]
      active[aaim_pkg::ALM_DATA_CORRUPT] = src_sync.data_corrupt;      // [RULE5]
      active[aaim_pkg::ALM_LOW_BATT] = batt_low;                       // [RULE6]
      active[aaim_pkg::ALM_TIME_DATE] = src_sync.time_bad | src_sync.date_bad; // [RULE7]
      active[aaim_pkg::ALM_JAM_AZ] = jam_w[0];                         // [RULE8]
      active[aaim_pkg::ALM_JAM_EL] = jam_w[1];
      active[aaim_pkg::ALM_JAM_POL] = jam_w[2];
      active[aaim_pkg::ALM_RUN_AZ] = run_w[0];                         // [RULE10]
      active[aaim_pkg::ALM_RUN_EL] = run_w[1];
      active[aaim_pkg::ALM_RUN_POL] = run_w[2];
      active[aaim_pkg::ALM_LIMITS_OFF] = src_sync.limits_off;          // [RULE12]
      active[aaim_pkg::ALM_OVERTEMP] = src_sync.overtemp & fitted.overtemp; // [RULE13]
      active[aaim_pkg::ALM_DRIVE_ERR] = src_sync.drive_err & fitted.drive_err; // [RULE14]
      active[aaim_pkg::ALM_ESTOP] = src_sync.estop;                    // [RULE15]
      active[aaim_pkg::ALM_CRANKS] = src_sync.cranks_unsafe & fitted.cranks; // [RULE17]
      active[aaim_pkg::ALM_EL_ILOCK] = src_sync.el_ilock_unsafe & fitted.el_ilock; // [RULE18]
      active[aaim_pkg::ALM_MOVE_ILOCK] =
         src_sync.move_ilock_unsafe & fitted.move_ilock;               // [RULE19]
      active[aaim_pkg::ALM_PENDANT] = src_sync.pendant;                // [RULE20]
   end

   // ----------------------------------------------------------------
   // Sequential priority scan
   // ----------------------------------------------------------------
   // One code is sampled per cycle, highest first. A full sweep takes
   // NUM_ALM cycles; the result is committed at sweep end, so a cleared
   // alarm gives way to the next one by the second sweep end. Trades a few
   // cycles of latency for a tiny comparator.
   logic [aaim_pkg::CODE_W-1:0] scan_idx;  // Code being sampled
   logic [aaim_pkg::CODE_W-1:0] best;      // Highest found this sweep

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scan_idx <= aaim_pkg::ALM_VER_MISMATCH;
         best <= aaim_pkg::ALM_NONE;
         alarm_code <= aaim_pkg::ALM_NONE;
         alarm_any <= 1'b0;
      end
      else
      begin
         if (scan_idx == aaim_pkg::ALM_PENDANT)
         begin
            // Sweep end: publish, including the last code sampled now
            if (best == aaim_pkg::ALM_NONE && active[scan_idx])
            begin
               alarm_code <= scan_idx;
               alarm_any <= 1'b1;
            end
            else
            begin
               alarm_code <= best;                       // [RULE2]
               alarm_any <= (best != aaim_pkg::ALM_NONE);
            end
            best <= aaim_pkg::ALM_NONE;
            scan_idx <= aaim_pkg::ALM_VER_MISMATCH;
         end
         else
         begin
            // First hit in a sweep is the highest priority one
            if (best == aaim_pkg::ALM_NONE && active[scan_idx])
               best <= scan_idx;                         // [RULE1] [RULE21]
            scan_idx <= scan_idx + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash timing for the bottom display line
   // ----------------------------------------------------------------
   logic [31:0] flash_cnt;                 // Half period counter

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flash_cnt <= '0;
         alarm_flash_on <= 1'b0;
      end
      else if (!alarm_any)
      begin
         flash_cnt <= '0;
         alarm_flash_on <= 1'b0;
      end
      else if (flash_cnt == 32'(aaim_pkg::FLASH_CYC - 1))
      begin
         flash_cnt <= '0;
         alarm_flash_on <= ~alarm_flash_on;              // [RULE3]
      end
      else
         flash_cnt <= flash_cnt + 32'h1;
   end

   // ----------------------------------------------------------------
   // Motion gating
   // ----------------------------------------------------------------
   // Registered gate; the watches see the same gated command, so a
   // blocked axis never counts toward a jam.
   logic [aaim_pkg::NUM_AXES-1:0] next_drive; // Allowed motion
   logic pend_now;                          // Pendant connected now

   always_comb
   begin
      pend_now = src_sync.pendant;
      next_drive = local_cmd | (pend_now ? '0 : remote_cmd); // [RULE20]
      next_drive = next_drive & ~jam_w;                    // [RULE9]
      next_drive = next_drive & ~run_w;                    // [RULE11]
      if (src_sync.estop)
         next_drive = '0;                                   // [RULE16]
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         drive_cmd <= '0;
         axis_jam <= '0;
         axis_runaway <= '0;
         remote_rejected <= 1'b0;
      end
      else
      begin
         drive_cmd <= next_drive;
         axis_jam <= jam_w;
         axis_runaway <= run_w;
         remote_rejected <= pend_now & (|remote_cmd);        // [RULE20]
      end
   end

endmodule

// file: tb/aaim_monitor_checker.sv
/*
 * Assertion checker for the alarm and interlock monitor top.
 * Sees only the top ports; bound to every instance of the top below.
 */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module aaim_monitor_checker
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire aaim_pkg::aaim_src_s src_pin,
   input wire logic [aaim_pkg::NUM_AXES-1:0] local_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] remote_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] axis_moved,
   input wire logic [aaim_pkg::NUM_AXES-1:0] fault_reset,
   input wire logic [aaim_pkg::CODE_W-1:0] alarm_code,
   input wire logic alarm_any,
   input wire logic alarm_flash_on,
   input wire logic [aaim_pkg::NUM_AXES-1:0] drive_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] axis_jam,
   input wire logic [aaim_pkg::NUM_AXES-1:0] axis_runaway,
   input wire logic remote_rejected
);
   // One domain, so one clock and one disable for all
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   any_tracks_code_a: assert property (alarm_any == (alarm_code != 5'h00))
      else $error("alarm flag disagrees with code");
   code_in_range_a: assert property (alarm_code <= aaim_pkg::ALM_PENDANT)
      else $error("alarm code out of range");
   // Published once per sweep, so never two changes close together
   code_holds_a: assert property ($changed(alarm_code) |=> $stable(alarm_code)[*8])
      else $error("alarm code changed mid sweep");
   estop_blocks_a: assert property (src_pin.estop[*4] |-> drive_cmd == 3'h0)
      else $error("motion while stop pressed");
   fault_blocks_a: assert property (
      |((axis_jam | axis_runaway) & $past(axis_jam | axis_runaway)) |->
      ((axis_jam | axis_runaway) & $past(axis_jam | axis_runaway) & drive_cmd) == 3'h0)
      else $error("faulted axis still driven");
   cmd_cause_a: assert property ((drive_cmd & ~$past(local_cmd | remote_cmd)) == 3'h0)
      else $error("drive without request");
   remote_flag_a: assert property (
      src_pin.pendant[*4] ##0 (remote_cmd != 3'h0) |=> remote_rejected)
      else $error("remote request not flagged");
   pendant_drop_a: assert property (
      src_pin.pendant[*4] |=> (drive_cmd & ~$past(local_cmd)) == 3'h0)
      else $error("remote request obeyed with pendant");
   run_cause_a: assert property (
      |(axis_runaway & ~$past(axis_runaway)) |->
      (axis_runaway & ~($past(axis_moved) | $past(axis_moved, 2) |
      $past(axis_moved, 3))) == 3'h0)
      else $error("runaway without movement");
   jam_clear_a: assert property (
      fault_reset[0] && axis_jam[0] |-> ##[1:3] !axis_jam[0])
      else $error("jam not cleared by pulse");
   run_clear_a: assert property (
      fault_reset[1] && !axis_moved[1] |-> ##[1:3] !axis_runaway[1])
      else $error("runaway not cleared by pulse");
   // Display goes dark once nothing is wrong
   flash_idle_a: assert property (!alarm_any |=> !alarm_flash_on)
      else $error("flashing with no alarm");

   // Main scenarios reached
   cover property (alarm_code == aaim_pkg::ALM_ESTOP);
   cover property (axis_jam[0]);
   cover property (axis_runaway[1]);
   cover property (remote_rejected);
endmodule

bind aaim_monitor aaim_monitor_checker u_chk
(
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .src_pin(src_pin),
   .local_cmd(local_cmd),
   .remote_cmd(remote_cmd),
   .axis_moved(axis_moved),
   .fault_reset(fault_reset),
   .alarm_code(alarm_code),
   .alarm_any(alarm_any),
   .alarm_flash_on(alarm_flash_on),
   .drive_cmd(drive_cmd),
   .axis_jam(axis_jam),
   .axis_runaway(axis_runaway),
   .remote_rejected(remote_rejected)
);

// file: tb/aaim_axis_model.sv
/*
 * Behavioural model of the three axis drives and their position sensing.
 * Assumes drive_cmd comes from the monitor on the same clock.
 */
`timescale 1ns/1ps
module aaim_axis_model
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [aaim_pkg::NUM_AXES-1:0] drive_cmd,
   input wire logic [aaim_pkg::NUM_AXES-1:0] stall,
   input wire logic [aaim_pkg::NUM_AXES-1:0] rogue,
   output logic [aaim_pkg::NUM_AXES-1:0] axis_moved
);
   logic [1:0] phase; // Step spacing, one step every four cycles

   // ----------------------------------------------------------------
   // Position steps
   // ----------------------------------------------------------------
   // Driven axes step unless held; rogue makes an unasked step
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phase <= 2'h0;
         axis_moved <= 3'h0;
      end
      else
      begin
         phase <= phase + 2'h1;
         axis_moved <= rogue | ({3{phase == 2'h3}} & drive_cmd & ~stall);
      end
   end
endmodule

// file: tb/tb_antenna_alarm_interlock_monitor.sv
/*
 * Self-checking bench for the alarm and interlock monitor.
 * Assumes the axis model and the bound checker are compiled beside it.
 */
`timescale 1ns/1ps
module tb_antenna_alarm_interlock_monitor;
   logic ref_clk;
   logic sys_rst;
   aaim_pkg::aaim_src_s src_pin; // Switch and status pins
   aaim_pkg::aaim_fit_s fitted;
   logic [aaim_pkg::ADC_W-1:0] batt_sample;
   logic batt_valid;
   logic [aaim_pkg::ADC_W-1:0] batt_low_thresh;
   logic [2:0] local_cmd, remote_cmd, axis_moved, fault_reset, stall, rogue;
   logic [31:0] jam_timeout_az, jam_timeout_el, jam_timeout_pol;
   logic [aaim_pkg::CODE_W-1:0] alarm_code;
   logic alarm_any, alarm_flash_on, remote_rejected;
   logic [2:0] drive_cmd, axis_jam, axis_runaway;
   logic [aaim_pkg::CODE_W-1:0] exp_code [12]; // Code while top pins clear
   int miscompares;
   int total_checks;

   aaim_monitor DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .src_pin(src_pin),
      .fitted(fitted), .batt_sample(batt_sample), .batt_valid(batt_valid),
      .batt_low_thresh(batt_low_thresh), .local_cmd(local_cmd), .remote_cmd(remote_cmd),
      .axis_moved(axis_moved), .jam_timeout_az(jam_timeout_az),
      .jam_timeout_el(jam_timeout_el), .jam_timeout_pol(jam_timeout_pol),
      .fault_reset(fault_reset), .alarm_code(alarm_code), .alarm_any(alarm_any),
      .alarm_flash_on(alarm_flash_on), .drive_cmd(drive_cmd), .axis_jam(axis_jam),
      .axis_runaway(axis_runaway), .remote_rejected(remote_rejected));
   aaim_axis_model u_axes (.ref_clk(ref_clk), .sys_rst(sys_rst), .drive_cmd(drive_cmd),
      .stall(stall), .rogue(rogue), .axis_moved(axis_moved));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Bounded wait for a code; a sweep is 18 cycles plus sync
   task automatic wait_code(input logic [aaim_pkg::CODE_W-1:0] exp);
      int i;
      i = 0;
      while (alarm_code !== exp && i < 80)
      begin
         cycles(1);
         i++;
      end
      check(alarm_code, exp);
      if (alarm_code !== exp)
         stop_test();
   endtask

   // Stall first so the last step never lands after the drive drops
   task automatic cmd_off();
      stall = 3'h7;
      cycles(2);
      local_cmd = 3'h0;
      remote_cmd = 3'h0;
      cycles(3);
      stall = 3'h0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      src_pin = '0;
      fitted = '1;
      batt_sample = 10'h000;
      batt_valid = 1'b0;
      batt_low_thresh = 10'h100;
      {local_cmd, remote_cmd, fault_reset, stall, rogue} = 15'h0000;
      jam_timeout_az = 32'h0000_0008; // Short so jams come quickly
      jam_timeout_el = 32'h0000_0100;
      jam_timeout_pol = 32'h0000_0100;
      miscompares = 0;
      total_checks = 0;
      exp_code = '{aaim_pkg::ALM_VER_MISMATCH, aaim_pkg::ALM_DATA_CORRUPT,
         aaim_pkg::ALM_TIME_DATE, aaim_pkg::ALM_TIME_DATE, aaim_pkg::ALM_LIMITS_OFF,
         aaim_pkg::ALM_OVERTEMP, aaim_pkg::ALM_DRIVE_ERR, aaim_pkg::ALM_ESTOP,
         aaim_pkg::ALM_CRANKS, aaim_pkg::ALM_EL_ILOCK, aaim_pkg::ALM_MOVE_ILOCK,
         aaim_pkg::ALM_PENDANT};
      cycles(10);
      check({alarm_code, alarm_any, drive_cmd, axis_jam, axis_runaway}, 32'h0);
      sys_rst = 1'b0;
      $display("test reset done");
      // All pins on, then clear from the top: each lower one shows in turn
      src_pin = '1;
      for (int i = 0; i < 12; i++)
      begin
         cycles(40);
         wait_code(exp_code[i]);
         src_pin = src_pin & ~(12'h800 >> i);
      end
      wait_code(aaim_pkg::ALM_NONE);
      check(alarm_flash_on, 1'b0);
      $display("test priority done");
      // Unfitted sources stay silent
      fitted = '0;
      src_pin = 12'h06e;
      cycles(60);
      check(alarm_code, aaim_pkg::ALM_NONE);
      fitted = '1;
      src_pin = '0;
      $display("test unfitted done");
      // Battery one below and at the threshold
      batt_sample = 10'h0ff;
      batt_valid = 1'b1;
      cycles(1);
      batt_valid = 1'b0;
      wait_code(aaim_pkg::ALM_LOW_BATT);
      batt_sample = 10'h100;
      batt_valid = 1'b1;
      cycles(1);
      batt_valid = 1'b0;
      wait_code(aaim_pkg::ALM_NONE);
      $display("test battery done");
      // Stop switch and pendant against local and remote requests
      local_cmd = 3'h1;
      remote_cmd = 3'h2;
      cycles(30);
      check({axis_jam, drive_cmd}, 6'h03);
      // Hold steps while the drive drops, so no late step reads as runaway
      stall = 3'h7;
      src_pin.estop = 1'b1;
      src_pin.pendant = 1'b1;
      cycles(4);
      stall = 3'h0;
      wait_code(aaim_pkg::ALM_ESTOP);
      check({remote_rejected, drive_cmd}, 4'h8);
      check({alarm_any, alarm_flash_on}, 2'h2);
      src_pin.estop = 1'b0;
      wait_code(aaim_pkg::ALM_PENDANT);
      check(drive_cmd, 3'h1);
      src_pin.pendant = 1'b0;
      wait_code(aaim_pkg::ALM_NONE);
      check(drive_cmd, 3'h3);
      cmd_off();
      $display("test stop and pendant done");
      // Commanded azimuth that never moves
      local_cmd = 3'h1;
      stall = 3'h1;
      wait_code(aaim_pkg::ALM_JAM_AZ);
      check({axis_jam, drive_cmd}, 6'h08);
      local_cmd = 3'h0;
      cycles(2);
      fault_reset = 3'h1;
      cycles(1);
      fault_reset = 3'h0;
      stall = 3'h0;
      wait_code(aaim_pkg::ALM_NONE);
      check(axis_jam, 3'h0);
      $display("test jam done");
      // Every axis moves with no command; clearing each uncovers the next
      rogue = 3'h7;
      cycles(1);
      rogue = 3'h0;
      wait_code(aaim_pkg::ALM_RUN_AZ);
      local_cmd = 3'h2;
      cycles(3);
      check({axis_runaway, drive_cmd}, 6'h38);
      local_cmd = 3'h0;
      cycles(2);
      for (int i = 0; i < 3; i++)
      begin
         fault_reset = 3'h1 << i;
         cycles(1);
         fault_reset = 3'h0;
         wait_code(i == 2 ? aaim_pkg::ALM_NONE : aaim_pkg::ALM_RUN_EL + 5'(i));
      end
      check(axis_runaway, 3'h0);
      $display("test runaway done");
      stop_test();
   end
endmodule
